// ==== core/ppp_regs.svh ====
// Register select codes, bit positions and reset values of the printer port.
// Included by the package users; holds definitions only.
`ifndef PPP_REGS_SVH
`define PPP_REGS_SVH
`define PPP_SEL_DATA 2'h0
`define PPP_SEL_STATUS 2'h1
`define PPP_SEL_CONTROL 2'h2
`define PPP_SEL_NONE 2'h3
`define PPP_CTL_STROBE 0
`define PPP_CTL_AUTOLF 1
`define PPP_CTL_INIT 2
`define PPP_CTL_SELIN 3
`define PPP_CTL_IRQGATE 4
`define PPP_CTL_RESET 5'h00
`define PPP_CTL_FILL 3'h7
`define PPP_STS_FILL 3'h7
`define PPP_DATA_RESET 8'h00
`endif

// ==== core/ppp_pkg.sv ====
// Types shared by the printer port design files.
// Assumes ppp_regs.svh is visible to the including modules.
package ppp_pkg;
    typedef enum logic [1:0] {
        PPP_ACC_IDLE = 2'b00,
        PPP_ACC_READ = 2'b01,
        PPP_ACC_WRITE = 2'b10,
        PPP_ACC_BAD = 2'b11
    } ppp_acc_t;
endpackage

// ==== core/ppp_buf2.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/10ps
module ppp_buf2 (
    input wire logic clk, // Clock
    input wire logic rst_b, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic [7:0] in_data, // Word in
    input wire logic in_valid, // Word in is valid
    output logic in_ready, // Space available
    output logic [7:0] out_data, // Oldest word, muxed from storage by the read pointer
    output logic out_valid, // Oldest word valid
    input wire logic out_ready // Drain accepts word
);
    logic [7:0] mem_reg [0:1];
    logic [1:0] cnt_reg;
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the count
    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_reg[0] <= 8'h00;
            mem_reg[1] <= 8'h00;
            wr_ptr_reg <= 1'b0;
        end else if (ce && push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
        end
    end

    // Read pointer and occupancy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (ce) begin
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end
endmodule

// ==== core/ppp_port.sv ====
// Printer parallel port: host-strobed register access, data/control lines.
// Assumes host strobes are synchronous to clk and held at least one cycle.
`timescale 1ns/10ps
`include "ppp_regs.svh"

// Notes on behaviour
// - Registers answer only while chip select low
// - Read or write chosen by active strobe
// - Data read returns live bus lines
// - Status read: top five bits printer status
// - Control read returns five control outputs
// - Control write sets five control outputs
// - Strobe asserted only while bus byte valid
// - Reset clears all five control outputs
// - Data write drives byte onto bus
module ppp_port
    import ppp_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic port_chip_select_n, // Port select, active low
    input wire logic host_read_strobe_n, // Host read, active low
    input wire logic host_write_strobe_n, // Host write, active low
    input wire logic reg_select_high, // Address bit 1
    input wire logic reg_select_low, // Address bit 0
    input wire logic [7:0] host_wdata, // Host write data
    output logic [7:0] host_rdata, // Read data, registered
    output logic host_rdata_oe, // High while driving host data
    input wire logic [7:0] par_in, // Bus lines sampled
    output logic [7:0] par_out, // Bus lines driven
    output logic par_oe, // High while driving bus
    input wire logic printer_busy, // Printer occupied
    input wire logic printer_ack, // Handshake acknowledge
    input wire logic paper_out, // Paper out
    input wire logic printer_online, // Printer online
    input wire logic printer_fault, // Fault
    output logic printer_interrupt_gate, // Interrupt gate
    output logic select_in_output, // Select-in
    output logic printer_init, // Printer reset request
    output logic auto_line_advance, // Auto line advance
    output logic byte_valid_pulse // Byte-valid strobe
);
    ppp_acc_t acc;
    logic [1:0] sel;
    logic [4:0] ctl_reg;
    logic [7:0] rdata_reg;
    logic rd_oe_reg;
    logic [7:0] par_out_reg;
    logic par_valid_reg;
    logic [7:0] buf_data;
    logic buf_valid;
    logic buf_in_ready;
    logic wr_data_hit;
    logic wr_ctl_hit;
    logic wr_prev_reg;

    // Decode strobes into one access kind per cycle
    function automatic ppp_acc_t ppp_decode(input logic cs_n, input logic rd_n,
                                            input logic wr_n);
        if (cs_n) begin
            ppp_decode = PPP_ACC_IDLE;
        end else begin
            case ({rd_n, wr_n})
                2'b01: ppp_decode = PPP_ACC_READ;
                2'b10: ppp_decode = PPP_ACC_WRITE;
                2'b11: ppp_decode = PPP_ACC_IDLE;
                default: ppp_decode = PPP_ACC_BAD;
            endcase
        end
    endfunction

    assign acc = ppp_decode(port_chip_select_n, host_read_strobe_n,
                            host_write_strobe_n);
    assign sel = {reg_select_high, reg_select_low};

    // A write takes effect once, on the strobe's leading cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_prev_reg <= 1'b0;
        end else if (ce) begin
            wr_prev_reg <= (acc == PPP_ACC_WRITE);
        end
    end

    assign wr_data_hit = (acc == PPP_ACC_WRITE) && !wr_prev_reg &&
                         (sel == `PPP_SEL_DATA);
    assign wr_ctl_hit = (acc == PPP_ACC_WRITE) && !wr_prev_reg &&
                        (sel == `PPP_SEL_CONTROL);

    // Data byte passes through a two-entry buffer toward the bus
    ppp_buf2 u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .in_data(host_wdata),
        .in_valid(wr_data_hit),
        .in_ready(buf_in_ready),
        .out_data(buf_data),
        .out_valid(buf_valid),
        .out_ready(!byte_valid_pulse)
    );

    // Bus output register; holding while strobe is high keeps byte stable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            par_out_reg <= `PPP_DATA_RESET;
            par_valid_reg <= 1'b0;
        end else if (ce && buf_valid && !byte_valid_pulse) begin
            par_out_reg <= buf_data;
            par_valid_reg <= 1'b1;
        end
    end

    assign par_out = par_out_reg;
    // The bus stays released until the first byte is written, so a reset
    // never leaves stale data driven toward the printer
    assign par_oe = par_valid_reg;

    // Control lines; strobe only taken while a byte is on the bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_reg <= `PPP_CTL_RESET;
        end else if (ce && wr_ctl_hit) begin
            ctl_reg <= host_wdata[4:0];
            ctl_reg[`PPP_CTL_STROBE] <= host_wdata[`PPP_CTL_STROBE] &&
                                        par_valid_reg && !buf_valid;
        end
    end

    assign printer_interrupt_gate = ctl_reg[`PPP_CTL_IRQGATE];
    assign select_in_output = ctl_reg[`PPP_CTL_SELIN];
    assign printer_init = ctl_reg[`PPP_CTL_INIT];
    assign auto_line_advance = ctl_reg[`PPP_CTL_AUTOLF];
    assign byte_valid_pulse = ctl_reg[`PPP_CTL_STROBE];

    // Read data register; invalid selects keep the last value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'hFF;
            rd_oe_reg <= 1'b0;
        end else if (ce) begin
            rd_oe_reg <= (acc == PPP_ACC_READ) && (sel != `PPP_SEL_NONE);
            if (acc == PPP_ACC_READ) begin
                case (sel)
                    `PPP_SEL_DATA: rdata_reg <= par_in;
                    `PPP_SEL_STATUS: rdata_reg <= {printer_busy, printer_ack,
                        paper_out, printer_online, printer_fault,
                        `PPP_STS_FILL};
                    `PPP_SEL_CONTROL: rdata_reg <= {`PPP_CTL_FILL,
                        ctl_reg};
                    default: rdata_reg <= rdata_reg;
                endcase
            end
        end
    end

    assign host_rdata = rdata_reg;
    assign host_rdata_oe = rd_oe_reg;

    // Access checks; the reset check looks one edge on, since the flops
    // may only settle at the first edge of a power-up reset
    AST_CTL_RESET: assert property (@(posedge clk)
        !rst_b |=> ctl_reg == `PPP_CTL_RESET)
        else $error("control lines not clear in reset");
    AST_CTL_WRITE: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && wr_ctl_hit |=> ctl_reg[4:1] == $past(host_wdata[4:1]))
        else $error("control write lost");
    AST_NO_SEL: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && port_chip_select_n |=> $stable(ctl_reg))
        else $error("control changed while deselected");
    AST_NO_SEL_RD: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && port_chip_select_n |=> !rd_oe_reg && $stable(rdata_reg))
        else $error("read answered while deselected");
    AST_RD_OE: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel != `PPP_SEL_NONE |=> rd_oe_reg)
        else $error("valid read not driven");
    AST_BOTH_STB: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_BAD |=> !rd_oe_reg && $stable(ctl_reg))
        else $error("access with both strobes acted");

    // Bus checks; a strobe must sit on a settled, valid byte
    AST_STB_VALID: assert property (@(posedge clk)
        disable iff (!rst_b)
        byte_valid_pulse |-> par_valid_reg)
        else $error("strobe without bus byte");
    AST_STB_HOLD: assert property (@(posedge clk)
        disable iff (!rst_b)
        byte_valid_pulse |=> $stable(par_out_reg))
        else $error("bus byte changed under strobe");
    AST_STB_GATE: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && wr_ctl_hit && buf_valid |=> !byte_valid_pulse)
        else $error("strobe raised with byte pending");
    AST_DATA_OUT: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && wr_data_hit && !buf_valid && !byte_valid_pulse |=> ##1
        par_out_reg == $past(host_wdata, 2))
        else $error("data byte did not reach bus");

    // Read data and invalid write checks, one cycle after the sampled access
    AST_RD_DATA: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel == `PPP_SEL_DATA |=>
        rdata_reg == $past(par_in))
        else $error("data read wrong");
    AST_RD_STS_TOP: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel == `PPP_SEL_STATUS |=>
        rdata_reg[7:3] == $past({printer_busy, printer_ack, paper_out,
        printer_online, printer_fault}))
        else $error("status lines misplaced");
    AST_RD_STATUS: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel == `PPP_SEL_STATUS |=>
        rdata_reg[2:0] == 3'h7 && rdata_reg[6] == $past(printer_ack))
        else $error("status read wrong");
    AST_RD_CTL: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel == `PPP_SEL_CONTROL |=>
        rdata_reg == {3'h7, $past(ctl_reg)})
        else $error("control read wrong");
    AST_BAD_WR: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_WRITE && sel[0] |=> $stable(ctl_reg))
        else $error("invalid write changed control");
    AST_BAD_RD: assert property (@(posedge clk)
        disable iff (!rst_b)
        ce && acc == PPP_ACC_READ && sel == `PPP_SEL_NONE |=>
        !rd_oe_reg && $stable(rdata_reg))
        else $error("invalid read answered");

    // Main scenarios that the bench should reach
    COV_DATA_WR: cover property (@(posedge clk) ce && wr_data_hit);
    COV_BAD_ACC: cover property (@(posedge clk) ce && acc == PPP_ACC_BAD);
    COV_STB: cover property (@(posedge clk) $rose(byte_valid_pulse));
    COV_FULL: cover property (@(posedge clk) !buf_in_ready);
    COV_STS_RD: cover property (@(posedge clk)
        acc == PPP_ACC_READ && sel == `PPP_SEL_STATUS);
endmodule

// ==== dv/ppp_printer.sv ====
// Printer model at the port's far side: takes bytes on strobe, answers.
// Assumes the port's outputs are registered on the rising clock edge.
`timescale 1ns/10ps
module ppp_printer #(
    parameter int ACK_DLY = 4
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic [7:0] par_out, // Byte driven by port
    input wire logic par_oe, // Port drives bus
    input wire logic strobe, // Byte-valid strobe
    input wire logic [2:0] sts_cmd, // Paper out, online, fault
    output logic [7:0] par_in, // Bus level
    output logic busy, // Occupied
    output logic ack, // Acknowledge
    output logic [7:0] taken // Last byte taken
);
    logic [7:0] last_reg;
    logic [3:0] cnt_reg;
    // A released bus shows the inverse, never a stale copy
    assign par_in = par_oe ? par_out : ~last_reg;
    // Occupied until it answers; the ack level is the handshake
    assign busy = strobe && (cnt_reg < ACK_DLY);
    assign ack = strobe && (cnt_reg >= ACK_DLY);
    // Bus history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            last_reg <= 8'h00;
        else if (par_oe)
            last_reg <= par_out;
    end
    // Strobe means a valid byte; take it on the first strobed edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
            taken <= 8'h00;
        end else if (!strobe) begin
            cnt_reg <= 4'h0;
        end else begin
            if (cnt_reg == 4'h0)
                taken <= par_in;
            if (cnt_reg != 4'hF)
                cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

// ==== dv/ppp_port_tb.sv ====
// Self-checking bench for the printer port, host side driven by tasks.
// Assumes host strobes held one cycle, inputs driven on falling edges.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
$display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module ppp_port_tb;
    typedef struct {logic rd; logic [1:0] sel; logic [7:0] d, e;} ppp_row_t;
    logic clk = 0, rst_b = 0, ce = 1, cs_n = 1, rd_n = 1, wr_n = 1;
    logic [1:0] sel = 2'h0;
    logic [7:0] wd = 8'h00, rdata, par_in, par_out, taken, got;
    logic oe, par_oe, busy, ack, got_oe;
    logic [2:0] sts = 3'h5;
    wire [4:0] ctl;
    int n_errors = 0, comparisons = 0;
    // First row reads the bus while it is still released
    ppp_row_t rows[12] = '{'{1, 0, 0, 8'hFF}, '{0, 2, 8'h1E, 0},
        '{1, 2, 0, 8'hFE}, '{0, 2, 8'h0A, 0}, '{1, 2, 0, 8'hEA},
        '{0, 2, 8'h14, 0}, '{1, 2, 0, 8'hF4}, '{0, 0, 8'hA5, 0},
        '{1, 0, 0, 8'hA5}, '{0, 0, 8'h5A, 0}, '{1, 0, 0, 8'h5A},
        '{1, 1, 0, 8'h2F}};
    ppp_port u_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .port_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
        .host_write_strobe_n(wr_n), .reg_select_high(sel[1]),
        .reg_select_low(sel[0]), .host_wdata(wd), .host_rdata(rdata),
        .host_rdata_oe(oe), .par_in(par_in), .par_out(par_out),
        .par_oe(par_oe), .printer_busy(busy), .printer_ack(ack),
        .paper_out(sts[2]), .printer_online(sts[1]),
        .printer_fault(sts[0]), .printer_interrupt_gate(ctl[4]),
        .select_in_output(ctl[3]), .printer_init(ctl[2]),
        .auto_line_advance(ctl[1]), .byte_valid_pulse(ctl[0]));
    ppp_printer #(.ACK_DLY(4)) u_prn (.clk(clk), .rst_b(rst_b),
        .par_out(par_out), .par_oe(par_oe), .strobe(ctl[0]),
        .sts_cmd(sts), .par_in(par_in), .busy(busy), .ack(ack),
        .taken(taken));
    // Free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    // One host cycle; answer caught at release, then two idle cycles
    task automatic acc(logic c, logic r, logic w, logic [1:0] s,
                       logic [7:0] d);
        @(negedge clk);
        {cs_n, rd_n, wr_n, sel, wd} = {c, r, w, s, d};
        @(negedge clk);
        {cs_n, rd_n, wr_n} = 3'b111;
        got = rdata;
        got_oe = oe;
        repeat (2) @(negedge clk);
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog, far beyond the under 150 cycles the tests need
    initial begin
        #40000;
        n_errors++;
        stop_test();
    end
    initial begin
        idle(12);
        rst_b = 1;
        foreach (rows[i]) begin
            acc(0, !rows[i].rd, rows[i].rd, rows[i].sel, rows[i].d);
            if (rows[i].rd)
                `CHK({got_oe, got}, {1'b1, rows[i].e})
            else if (rows[i].sel == 2'h0)
                `CHK(par_out, rows[i].d)
        end
        $display("test table done");
        // Byte, then strobe; printer answers through the status register
        acc(0, 1, 0, 2'h0, 8'h3C);
        acc(0, 1, 0, 2'h2, 8'h01);
        `CHK(ctl, 5'h01)
        acc(0, 0, 1, 2'h1, 8'h00);
        `CHK(got, 8'hAF)
        idle(4);
        acc(0, 0, 1, 2'h1, 8'h00);
        `CHK(got, 8'h6F)
        `CHK(taken, 8'h3C)
        // Bytes written while strobe is up wait; third one is dropped
        acc(0, 1, 0, 2'h0, 8'h77);
        acc(0, 1, 0, 2'h0, 8'h88);
        acc(0, 1, 0, 2'h0, 8'h99);
        `CHK(par_out, 8'h3C)
        acc(0, 1, 0, 2'h2, 8'h00);
        idle(4);
        acc(0, 0, 1, 2'h0, 8'h00);
        `CHK(got, 8'h88)
        $display("test strobe done");
        // Refused accesses and a frozen clock enable change nothing
        acc(0, 1, 0, 2'h1, 8'h11);
        acc(0, 1, 0, 2'h3, 8'h22);
        acc(1, 1, 0, 2'h0, 8'h33);
        acc(0, 0, 0, 2'h2, 8'h1F);
        ce = 0;
        acc(0, 1, 0, 2'h2, 8'h1E);
        ce = 1;
        `CHK(par_out, 8'h88)
        `CHK(ctl, 5'h00)
        acc(0, 0, 1, 2'h3, 8'h00);
        `CHK({got_oe, got}, 9'h088)
        $display("test refused done");
        // Reset in mid-run clears the control lines
        acc(0, 1, 0, 2'h2, 8'h1E);
        `CHK(ctl, 5'h1E)
        rst_b = 0;
        idle(2);
        `CHK(ctl, 5'h00)
        `CHK({oe, par_oe, rdata, par_out}, 18'h0FF00)
        rst_b = 1;
        acc(0, 0, 1, 2'h2, 8'h00);
        `CHK(got, 8'hE0)
        acc(0, 0, 1, 2'h0, 8'h00);
        `CHK(got, 8'hFF)
        $display("test reset done");
        stop_test();
    end
endmodule
